//--- core/asr_buf2.sv
// Purpose : Two-entry valid/ready buffer for captured sample words
// Assumes : Single clock, synchronous active-high reset
// Notes   : Full only when both entries hold data; never drops a word
`timescale 1ns/1ps
module asr_buf2 #(
   parameter int WIDTH = 11
) (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   // Fill side
   input  wire logic             s_valid_in,
   output logic                  s_ready_out,
   input  wire logic [WIDTH-1:0] s_data_in,
   // Drain side
   output logic                  m_valid_out,
   input  wire logic             m_ready_in,
   output logic [WIDTH-1:0]      m_data_out
);
   logic [WIDTH-1:0] mem_r [2];
   logic             wr_ptr_r;
   logic             rd_ptr_r;
   logic [1:0]       cnt_r;
   logic             push;
   logic             pop;

   initial begin
      if (WIDTH < 1) $error("asr_buf2: WIDTH must be positive");
   end

   // Handshakes straight from occupancy
   assign s_ready_out = (cnt_r != 2'h2);
   assign m_valid_out = (cnt_r != 2'h0);
   assign push        = s_valid_in && s_ready_out;
   assign pop         = m_valid_out && m_ready_in;

   // Storage write
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_r[wr_ptr_r] <= s_data_in;
      end
   end

   // Pointers and count
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wr_ptr_r <= 1'b0;
         rd_ptr_r <= 1'b0;
         cnt_r    <= 2'h0;
      end else begin
         if (push) wr_ptr_r <= ~wr_ptr_r;
         if (pop)  rd_ptr_r <= ~rd_ptr_r;
         if (push && !pop)      cnt_r <= cnt_r + 2'h1;
         else if (pop && !push) cnt_r <= cnt_r - 2'h1;
      end
   end

   // Head word from a register-held memory entry
   assign m_data_out = mem_r[rd_ptr_r];
endmodule : asr_buf2

//--- core/asr_pkg.sv
// Purpose : Shared constants for the converter sample readout block
// Assumes : One 50 MHz system clock, conversion strobe arrives as a pin
// Notes   : Analog input is modelled as a signed digital level per step
package asr_pkg;
   // ----------------------------------------------------------------
   // Word layout and coding
   // ----------------------------------------------------------------
   localparam int          ASR_DATA_W   = 10;
   localparam int          ASR_LEVEL_W  = 12;
   localparam logic [9:0]  ASR_CODE_PFS = 10'h3FF;  // Positive full scale, all ones
   localparam logic [9:0]  ASR_CODE_NFS = 10'h000;  // Negative full scale, all zeros
   localparam logic [9:0]  ASR_CODE_PHS = 10'h300;  // Positive half scale 1100000000
   localparam logic [9:0]  ASR_CODE_MID = 10'h200;  // Bipolar zero
   // Signed input level: 0 is bipolar zero, one count per step
   localparam logic signed [11:0] ASR_LVL_MAX = 12'sh1FF;
   localparam logic signed [11:0] ASR_LVL_MIN = -12'sh200;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int ASR_CLK_MHZ       = 50;
   localparam int ASR_LAT_HALVES    = 5;           // Two and a half strobe periods
   localparam int ASR_TPR_NS        = 20;          // Output propagation delay
   localparam int ASR_TPR_CYC       = (ASR_TPR_NS * ASR_CLK_MHZ + 999) / 1000;
   localparam int ASR_BUF_DEPTH     = 2;
endpackage : asr_pkg

//--- core/asr_readout.sv
// Purpose : Digital readout of a 10-bit pipelined sampling converter
// Assumes : Strobe and analog level arrive from outside, are synchronised
// Notes   : The strobe is oversampled by the 50 MHz clock; strobe must be slower
//           The level is taken only once two synchronised samples of it agree
//
// Summary of operation
// (R1) Strobe source keeps 50 percent duty, within ten percent.
// (R2) Strobe source never runs below the minimum sample rate.
// (R3) Strobe must be continuous and free running, no bursts.
// (R4) Each strobe rising edge captures the input and starts a conversion.
// (R5) Result appears two and a half strobe periods after its capture edge.
// (R6) Output word updates one propagation delay after each falling edge.
// (R7) Offset binary: all ones top, all zeros bottom, 1100000000 half scale.
// (R8) Below negative full scale by one step: flag high, word all zeros.
// (R9) Flag is active high for over-range in either direction, else low.
// (R10) Receiver buffers the data lines close to the device.
// (R11) Receiver takes word and flag as one valid sample per period.
`timescale 1ns/1ps
module asr_readout
   import asr_pkg::*;
#(
   parameter int TPR_CYC = asr_pkg::ASR_TPR_CYC
) (
   // Clock and reset
   input  wire logic                          CLK_SYS_IN,
   input  wire logic                          SYS_RST_IN,
   // Conversion strobe and analog level from outside
   input  wire logic                          STROBE_IN,
   input  wire logic signed [ASR_LEVEL_W-1:0] ANALOG_INPUT_IN,
   // Output pins of the converter
   output logic [ASR_DATA_W-1:0]              SAMPLE_WORD_BITS_OUT,
   output logic                               OUT_OF_RANGE_OUT,
   // Buffered sample stream to capture logic
   output logic                               SAMPLE_VALID_OUT,
   input  wire logic                          SAMPLE_READY_IN,
   output logic [ASR_DATA_W:0]                SAMPLE_DATA_OUT,
   output logic                               SAMPLE_LOST_OUT
);
   import asr_pkg::*;

   localparam int PIPE = ASR_LAT_HALVES;

   initial begin
      if (TPR_CYC < 1 || TPR_CYC > 255) $error("asr_readout: TPR_CYC out of range");
      if (ASR_BUF_DEPTH != 2) $error("asr_readout: buffer holds exactly two words");
      if (PIPE < 2) $error("asr_readout: pipeline needs two stages or more");
   end

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic                          stb_m_r, stb_s_r, stb_d_r;
   logic signed [ASR_LEVEL_W-1:0] lvl_m_r, lvl_s_r;
   logic signed [ASR_LEVEL_W-1:0] lvl_d_r, lvl_q_r;
   logic                          stb_rise, stb_fall;

   // Two flops on the strobe and level inputs before any logic reads them
   always_ff @(posedge CLK_SYS_IN) begin
      stb_m_r <= STROBE_IN;
      stb_s_r <= stb_m_r;
      lvl_m_r <= ANALOG_INPUT_IN;
      lvl_s_r <= lvl_m_r;
   end

   // Bits of a moving level may land on different clocks; a word is taken
   // only once two synchronised samples agree, at one clock of extra aperture
   always_ff @(posedge CLK_SYS_IN) begin
      lvl_d_r <= lvl_s_r;
      if (lvl_s_r == lvl_d_r) lvl_q_r <= lvl_s_r;
   end

   // Edge history of the synchronised strobe; it follows the pin through reset,
   // so a release while the strobe is high yields no false rising edge
   always_ff @(posedge CLK_SYS_IN) begin
      stb_d_r <= stb_s_r;
   end

   // Edges are seen two clocks after the pin; pins and stream share that lag
   assign stb_rise = stb_s_r && !stb_d_r;
   assign stb_fall = !stb_s_r && stb_d_r;

   // ----------------------------------------------------------------
   // Quantiser
   // ----------------------------------------------------------------
   logic [ASR_DATA_W-1:0] q_code;
   logic                  q_oor;

   // (R7) Offset binary coding
   // (R8) Clamp below range
   // (R9) Flag either side
   always_comb begin
      q_oor  = 1'b0;
      q_code = ASR_CODE_MID;
      if (lvl_q_r > ASR_LVL_MAX) begin
         q_oor  = 1'b1;
         q_code = ASR_CODE_PFS;
      end else if (lvl_q_r < ASR_LVL_MIN) begin
         q_oor  = 1'b1;
         q_code = ASR_CODE_NFS;
      end else begin
         q_code = ASR_DATA_W'(lvl_q_r - ASR_LVL_MIN);
      end
   end

   // ----------------------------------------------------------------
   // Conversion pipeline, one stage per strobe half period
   // ----------------------------------------------------------------
   logic [ASR_DATA_W:0] stage_r [PIPE];
   logic [PIPE-1:0]     stage_v_r;
   logic                half_edge;

   assign half_edge = stb_rise || stb_fall;

   // (R4) Capture on rising edge
   always_ff @(posedge CLK_SYS_IN) begin
      if (SYS_RST_IN) begin
         stage_v_r <= '0;
      end else if (half_edge) begin
         stage_v_r <= {stage_v_r[PIPE-2:0], stb_rise};
      end
   end

   // (R5) Two and a half periods
   generate
      for (genvar i = 0; i < PIPE; i++) begin : g_stage
         if (i == 0) begin : g_head
            // Head stage loads a new code only at a rising edge
            always_ff @(posedge CLK_SYS_IN) begin
               if (SYS_RST_IN) begin
                  stage_r[i] <= '0;
               end else if (half_edge && stb_rise) begin
                  stage_r[i] <= {q_oor, q_code};
               end
            end
         end else begin : g_tail
            // Later stages shift at every half period
            always_ff @(posedge CLK_SYS_IN) begin
               if (SYS_RST_IN) begin
                  stage_r[i] <= '0;
               end else if (half_edge) begin
                  stage_r[i] <= stage_r[i-1];
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Output propagation delay after the falling edge
   // ----------------------------------------------------------------
   logic [7:0]          tpr_cnt_r;
   logic                tpr_busy_r;
   logic                upd;
   logic [ASR_DATA_W:0] held_r;
   logic                held_v_r;

   // Latch the pipeline tail at the falling edge, release after delay
   always_ff @(posedge CLK_SYS_IN) begin
      if (SYS_RST_IN) begin
         held_r   <= '0;
         held_v_r <= 1'b0;
      end else if (stb_fall) begin
         held_r   <= stage_r[PIPE-1];
         held_v_r <= stage_v_r[PIPE-1];
      end
   end

   // (R6) Delay after fall
   always_ff @(posedge CLK_SYS_IN) begin
      if (SYS_RST_IN) begin
         tpr_cnt_r  <= 8'h00;
         tpr_busy_r <= 1'b0;
      end else if (stb_fall) begin
         tpr_cnt_r  <= 8'(TPR_CYC - 1);
         tpr_busy_r <= 1'b1;
      end else if (tpr_busy_r) begin
         if (tpr_cnt_r == 8'h00) tpr_busy_r <= 1'b0;
         else                    tpr_cnt_r  <= tpr_cnt_r - 8'h01;
      end
   end

   assign upd = tpr_busy_r && (tpr_cnt_r == 8'h00);

   // Output pins change only at the update point
   always_ff @(posedge CLK_SYS_IN) begin
      if (SYS_RST_IN) begin
         SAMPLE_WORD_BITS_OUT <= ASR_CODE_NFS;
         OUT_OF_RANGE_OUT     <= 1'b0;
      end else if (upd) begin
         SAMPLE_WORD_BITS_OUT <= held_r[ASR_DATA_W-1:0];
         OUT_OF_RANGE_OUT     <= held_r[ASR_DATA_W];
      end
   end

   // ----------------------------------------------------------------
   // Sample stream through the two-entry buffer
   // ----------------------------------------------------------------
   logic buf_ready;
   logic push_v;

   // Only words that carry a real capture enter the stream, never reset zeros
   assign push_v = upd && held_v_r;

   // Sticky flag when the receiver stalled long enough to overflow the buffer
   always_ff @(posedge CLK_SYS_IN) begin
      if (SYS_RST_IN)              SAMPLE_LOST_OUT <= 1'b0;
      else if (push_v && !buf_ready) SAMPLE_LOST_OUT <= 1'b1;
   end

   // The buffer rides out a receiver stall of up to two strobe periods
   asr_buf2 #(
      .WIDTH       (ASR_DATA_W + 1)
   ) u_buf (
      .clk_in      (CLK_SYS_IN),
      .rst_in      (SYS_RST_IN),
      .s_valid_in  (push_v),
      .s_ready_out (buf_ready),
      .s_data_in   (held_r),
      .m_valid_out (SAMPLE_VALID_OUT),
      .m_ready_in  (SAMPLE_READY_IN),
      .m_data_out  (SAMPLE_DATA_OUT)
   );
endmodule : asr_readout

//--- dv/asr_chk.sv
// Purpose : Assertions on readout pins and sample stream
// Assumes : Strobe half period of at least eight clocks
// Notes   : Bound into asr_readout after the module
`timescale 1ns/1ps
module asr_chk (
   // Clock, reset and inputs
   input wire logic        CLK_SYS_IN,
   input wire logic        SYS_RST_IN,
   input wire logic        STROBE_IN,
   input wire logic        SAMPLE_READY_IN,
   // Watched outputs
   input wire logic [9:0]  SAMPLE_WORD_BITS_OUT,
   input wire logic        OUT_OF_RANGE_OUT,
   input wire logic        SAMPLE_VALID_OUT,
   input wire logic [10:0] SAMPLE_DATA_OUT,
   input wire logic        SAMPLE_LOST_OUT
);
   default clocking @(posedge CLK_SYS_IN); endclocking
   default disable iff (SYS_RST_IN);
   // Flag only rides on an end-of-scale word
   a_flag_word: assert property (
      OUT_OF_RANGE_OUT |-> SAMPLE_WORD_BITS_OUT inside {10'h000, 10'h3FF})
      else $error("flag with mid-scale word");
   // Pins move only in the low half, after a fall
   a_pin_edge: assert property (
      $changed({OUT_OF_RANGE_OUT, SAMPLE_WORD_BITS_OUT}) |-> !STROBE_IN && !$past(STROBE_IN))
      else $error("pins moved outside low half");
   // An update holds the pins stable for the next eight clocks
   a_pin_rate: assert property (
      $changed({OUT_OF_RANGE_OUT, SAMPLE_WORD_BITS_OUT})
      |=> $stable({OUT_OF_RANGE_OUT, SAMPLE_WORD_BITS_OUT}) [*8])
      else $error("pins updated twice in a period");
   // Fresh stream head equals the pins just pushed
   a_push_pins: assert property (
      $rose(SAMPLE_VALID_OUT) |-> SAMPLE_DATA_OUT == {OUT_OF_RANGE_OUT, SAMPLE_WORD_BITS_OUT})
      else $error("stream word differs from pins");
   // Stalled head must not move or vanish
   a_stall_hold: assert property (
      SAMPLE_VALID_OUT && !SAMPLE_READY_IN |=> SAMPLE_VALID_OUT && $stable(SAMPLE_DATA_OUT))
      else $error("stalled word changed");
   // Loss flag clears only by reset
   a_lost_sticky: assert property (
      SAMPLE_LOST_OUT |=> SAMPLE_LOST_OUT)
      else $error("loss flag dropped");
endmodule : asr_chk

bind asr_readout asr_chk u_chk (
   .CLK_SYS_IN(CLK_SYS_IN), .SYS_RST_IN(SYS_RST_IN), .STROBE_IN(STROBE_IN),
   .SAMPLE_READY_IN(SAMPLE_READY_IN), .SAMPLE_WORD_BITS_OUT(SAMPLE_WORD_BITS_OUT),
   .OUT_OF_RANGE_OUT(OUT_OF_RANGE_OUT), .SAMPLE_VALID_OUT(SAMPLE_VALID_OUT),
   .SAMPLE_DATA_OUT(SAMPLE_DATA_OUT), .SAMPLE_LOST_OUT(SAMPLE_LOST_OUT));

//--- dv/asr_readout_tb.sv
// Purpose : Self-checking bench for the sample readout
// Assumes : Strobe half period eight clocks, TPR_CYC of one
// Notes   : Outputs sampled on the falling clock edge
`timescale 1ns/1ps
module asr_readout_tb;
   import asr_pkg::*;
   logic                          clk = 1'b0;
   logic                          rst = 1'b1;
   logic                          strobe;
   logic signed [ASR_LEVEL_W-1:0] level = '0;
   logic                          ready = 1'b1;
   logic [ASR_DATA_W-1:0]         word;
   logic                          oor;
   logic                          valid;
   logic                          lost;
   logic [ASR_DATA_W:0]           data;
   int                            fail_count = 0;
   int                            checked = 0;
   int                            cycles = 0;
   asr_strobe_src #(.HALF(8)) u_src (.clk_in(clk), .strobe_out(strobe));
   asr_readout uut (.CLK_SYS_IN(clk), .SYS_RST_IN(rst), .STROBE_IN(strobe),
      .ANALOG_INPUT_IN(level), .SAMPLE_WORD_BITS_OUT(word), .OUT_OF_RANGE_OUT(oor),
      .SAMPLE_VALID_OUT(valid), .SAMPLE_READY_IN(ready), .SAMPLE_DATA_OUT(data),
      .SAMPLE_LOST_OUT(lost));
   initial begin
      forever #10 clk = ~clk;
   end
   task automatic end_of_test();
      if (fail_count == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_of_test
   // Hang guard, far above the roughly one thousand cycles needed
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         fail_count++;
         $display("MISMATCH %0t timeout", $time);
         end_of_test();
      end
   end
   task automatic check(input logic [11:0] got, input logic [11:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
   endtask : check
   // Codes at both ends, half scale, zero and just beyond range
   task automatic t_coding();
      logic signed [11:0] lv [9] = '{12'sd511, 12'sd510, 12'sd256, 12'sd255, 12'sd0,
         -12'sd1, -12'sd512, -12'sd513, 12'sd512};
      logic [10:0] ex [9] = '{11'h3FF, 11'h3FE, 11'h300, 11'h2FF, 11'h200,
         11'h1FF, 11'h000, 11'h400, 11'h7FF};
      for (int i = 0; i < 9; i++) begin
         @(posedge clk) level <= lv[i];
         repeat (5) @(negedge strobe);
         repeat (6) @(negedge clk);
         check({oor, word}, ex[i]);
      end
   endtask : t_coding
   // New level captured at one rise, then changed while strobe is high
   task automatic t_latency();
      @(negedge strobe) level <= 12'sd100;
      @(posedge strobe);
      repeat (4) @(posedge clk);
      level <= -12'sd200;
      repeat (32) @(negedge clk);
      check({oor, word}, 11'h7FF);
      repeat (12) @(negedge clk);
      check({oor, word}, 11'h264);
   endtask : t_latency
   // Receiver stalls past two words, then drains back to back
   task automatic t_stall();
      repeat (3) @(negedge strobe);
      ready <= 1'b0;
      repeat (5) @(negedge strobe);
      repeat (6) @(negedge clk);
      check({valid, lost}, 2'b11);
      @(posedge clk) ready <= 1'b1;
      repeat (2) begin
         @(negedge clk);
         check({valid, data}, 12'h938);
      end
      @(negedge clk);
      check({valid, lost}, 2'b01);
   endtask : t_stall
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_coding();
      t_latency();
      t_stall();
      end_of_test();
   end
endmodule : asr_readout_tb

//--- dv/asr_strobe_src.sv
// Purpose : Free-running conversion strobe source
// Assumes : Clocked by the bench system clock
// Notes   : Never gated, so no burst case exists here
`timescale 1ns/1ps
module asr_strobe_src #(
   parameter int HALF = 8
) (
   input  wire logic clk_in,
   output logic      strobe_out
);
   int cnt_r;
   initial begin
      cnt_r = 0;
      strobe_out = 1'b0;
   end
   always @(posedge clk_in) begin
      cnt_r <= (cnt_r == HALF - 1) ? 0 : cnt_r + 1;
      if (cnt_r == HALF - 1) strobe_out <= ~strobe_out;
   end
endmodule : asr_strobe_src
